// file: src/crsf_top.sv
/*
 * Card reset release sequencer and supply fault supervisor with its
 * SFR registers. Assumes single-cycle SFR strobes on CLK, an ETU tick
 * pulse on CLK from the card baud logic, and asynchronous pins for
 * card supply good and the low-supply comparator.
 */
`timescale 1ns/1ns
`include "crsf_map.svh"

// Operation
// - Eight-bit register gives card reset release delay in ETUs.
// - Delay zero and hold clear: release reset once card supply is good.
// - Nonzero delay postpones reset release by that many ETUs.
// - Setting the hold bit drives card reset low.
// - Clearing the hold bit releases reset after the programmed delay.
// - Hold set before power-up keeps reset low until cleared plus delay.
// - Hold and delay act only on the selected card interface.
// - Enabled fault detection deactivates active interface on low supply.
// - Override bit picks threshold field, otherwise the factory default.
// - Fault disable bit set stops any deactivation from low supply.
// - Threshold code 000 is 2.3 V, plus 0.1 V per step to 3.0 V.
// - Factory default threshold is fuse set to any of eight codes.
module crsf_top (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// SFR access
	input wire crsf_pkg::crsf_sfr_req_s SFR_REQ,
	output logic [7:0] SFR_RDATA,
	// Card baud logic
	input wire logic ETU_TICK,
	// Card side
	input wire logic CARD_SUPPLY_GOOD,
	output logic [1:0] CARD_POWER_EN,
	output logic [1:0] CARD_RST_N,
	// Supply supervision
	input wire logic SUPPLY_LOW,
	input wire logic [2:0] FUSE_THRESHOLD,
	output logic [2:0] SUPPLY_THRESHOLD
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1_r;
	logic rst_s2_r;
	logic rst_n_i;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	assign rst_n_i = rst_s2_r;

	// ----------------------------------------
	// Supply fault detector
	// ----------------------------------------
	crsf_pkg::crsf_state_s r;
	crsf_pkg::crsf_state_s n;
	logic fault_i;

	crsf_fault_det u_fault (
		.clk(CLK),
		.rst_n(rst_n_i),
		.supply_low(SUPPLY_LOW),
		.fuse_code(FUSE_THRESHOLD),
		.fctl(r.fctl),
		.thr_code(SUPPLY_THRESHOLD),
		.fault(fault_i)
	);

	// ----------------------------------------
	// Registers and sequencer
	// ----------------------------------------
	logic hold;
	logic sel_ok;
	logic keep;
	logic wr_sel;
	logic [15:0] addr;

	always_comb
	begin
		n = r;
		addr = SFR_REQ.addr;
		hold = r.contact[`CRSF_CONTACT_HOLD_BIT];
		sel_ok = r.if_sel < `CRSF_NUM_IF;
		wr_sel = SFR_REQ.wr && addr == `CRSF_ADDR_SELECT;
		n.good = crsf_pkg::crsf_sync_step(r.good, CARD_SUPPLY_GOOD);

		if (SFR_REQ.wr)
		begin
			unique case (addr)
				`CRSF_ADDR_SELECT:
				begin
					n.if_sel = SFR_REQ.wdata[`CRSF_SELECT_HI:`CRSF_SELECT_LO];
				end
				`CRSF_ADDR_POWER:
				begin
					n.vcc_sel = SFR_REQ.wdata[`CRSF_POWER_SEL_HI:`CRSF_POWER_SEL_LO];
					if (SFR_REQ.wdata[`CRSF_POWER_FLAG_BIT])
					begin
						n.flag = 1'b0;
					end
				end
				`CRSF_ADDR_CONTACT:
				begin
					n.contact = SFR_REQ.wdata;
				end
				`CRSF_ADDR_RLEN:
				begin
					n.rlen = SFR_REQ.wdata;
				end
				`CRSF_ADDR_FAULT:
				begin
					n.fctl = SFR_REQ.wdata & `CRSF_FAULT_WMASK;
				end
				default:
				begin
				end
			endcase
		end

		// deactivate on fault; flag set beats clear
		if (fault_i)
		begin
			n.flag = 1'b1;
			n.vcc_sel = 2'h0;
		end

		// Next power select, so card reset never outlives card power by a cycle
		keep = (n.vcc_sel != 2'h0) && sel_ok && !fault_i && !(wr_sel && n.if_sel != r.if_sel);

		unique case (r.seq)
			crsf_pkg::SEQ_OFF:
			begin
				n.seq = crsf_pkg::SEQ_WAIT_GOOD;
			end
			crsf_pkg::SEQ_WAIT_GOOD:
			begin
				if (r.good.stable)
				begin
					if (hold)
					begin
						n.seq = crsf_pkg::SEQ_HOLD;
					end
					else
					begin
						n.cnt = 8'h00;
						n.seq = (r.rlen == 8'h00) ? crsf_pkg::SEQ_RUN : crsf_pkg::SEQ_DELAY;
					end
				end
			end
			crsf_pkg::SEQ_HOLD:
			begin
				if (!hold)
				begin
					n.cnt = 8'h00;
					if (!r.good.stable)
					begin
						n.seq = crsf_pkg::SEQ_WAIT_GOOD;
					end
					else
					begin
						n.seq = (r.rlen == 8'h00) ? crsf_pkg::SEQ_RUN : crsf_pkg::SEQ_DELAY;
					end
				end
			end
			// count ETU ticks up to the delay value
			crsf_pkg::SEQ_DELAY:
			begin
				if (hold)
				begin
					n.seq = crsf_pkg::SEQ_HOLD;
				end
				else if (ETU_TICK)
				begin
					if (r.cnt + 8'h01 >= r.rlen)
					begin
						n.seq = crsf_pkg::SEQ_RUN;
					end
					else
					begin
						n.cnt = r.cnt + 8'h01;
					end
				end
			end
			crsf_pkg::SEQ_RUN:
			begin
				if (hold)
				begin
					n.seq = crsf_pkg::SEQ_HOLD;
				end
				else if (!r.good.stable)
				begin
					n.seq = crsf_pkg::SEQ_WAIT_GOOD;
				end
			end
		endcase

		// Power loss, fault or a new selection restarts from reset
		if (!keep)
		begin
			n.seq = crsf_pkg::SEQ_OFF;
		end

		// only the selected interface is powered and released
		n.pwr = 2'h0;
		n.rst_n = 2'h0;
		if (n.if_sel < `CRSF_NUM_IF)
		begin
			n.pwr[n.if_sel[0]] = n.vcc_sel != 2'h0;
			n.rst_n[n.if_sel[0]] = n.seq == crsf_pkg::SEQ_RUN;
		end

		if (SFR_REQ.rd)
		begin
			unique case (addr)
				`CRSF_ADDR_SELECT: n.rdata = {4'h0, r.if_sel, 2'h0};
				`CRSF_ADDR_POWER: n.rdata = {r.vcc_sel, r.flag, 1'b0, r.good.stable, 3'h0};
				`CRSF_ADDR_CONTACT: n.rdata = r.contact;
				`CRSF_ADDR_RLEN: n.rdata = r.rlen;
				`CRSF_ADDR_FAULT: n.rdata = r.fctl;
				default: n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			r <= '0;
			r.rlen <= `CRSF_RLEN_RESET;
			r.contact <= `CRSF_CONTACT_RESET;
			r.fctl <= `CRSF_FAULT_RESET;
		end
		else
		begin
			r <= n;
		end
	end

	assign SFR_RDATA = r.rdata;
	assign CARD_POWER_EN = r.pwr;
	assign CARD_RST_N = r.rst_n;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!rst_n_i);

	property p_zero_delay;
		(r.seq == crsf_pkg::SEQ_WAIT_GOOD && r.good.stable && !hold && r.rlen == 8'h00 && keep)
			|=> (r.seq == crsf_pkg::SEQ_RUN && CARD_RST_N[r.if_sel[0]]);
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("no immediate release");
	property p_delay_wait;
		(r.seq == crsf_pkg::SEQ_DELAY && !ETU_TICK && !hold && keep)
			|=> (r.seq == crsf_pkg::SEQ_DELAY && $stable(r.cnt) && CARD_RST_N == 2'h0);
	endproperty
	a_delay_wait: assert property (p_delay_wait) else $error("delay moved without tick");
	property p_delay_end;
		(r.seq == crsf_pkg::SEQ_DELAY && ETU_TICK && !hold && keep && r.cnt + 8'h01 == r.rlen)
			|=> r.seq == crsf_pkg::SEQ_RUN;
	endproperty
	a_delay_end: assert property (p_delay_end) else $error("release not at delay end");
	property p_hold_low;
		hold[*2] |-> CARD_RST_N == 2'h0;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("reset released under hold");
	property p_hold_clear;
		(r.seq == crsf_pkg::SEQ_HOLD && !hold && r.good.stable && r.rlen != 8'h00 && keep)
			|=> (r.seq == crsf_pkg::SEQ_DELAY && r.cnt == 8'h00 && CARD_RST_N == 2'h0);
	endproperty
	a_hold_clear: assert property (p_hold_clear) else $error("hold clear skipped delay");
	property p_hold_powerup;
		(r.seq == crsf_pkg::SEQ_OFF && hold) ##1 hold |-> CARD_RST_N == 2'h0;
	endproperty
	a_hold_powerup: assert property (p_hold_powerup) else $error("power-up ignored hold");
	property p_select_only;
		(r.if_sel >= `CRSF_NUM_IF) ? (CARD_RST_N == 2'h0 && CARD_POWER_EN == 2'h0)
			: (CARD_RST_N[~r.if_sel[0]] == 1'b0 && CARD_POWER_EN[~r.if_sel[0]] == 1'b0);
	endproperty
	a_select_only: assert property (p_select_only) else $error("unselected interface active");
	property p_fault_off;
		fault_i |=> (CARD_POWER_EN == 2'h0 && CARD_RST_N == 2'h0 && r.flag);
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault did not deactivate");
	property p_restart;
		(r.seq != crsf_pkg::SEQ_DELAY) ##1 (r.seq == crsf_pkg::SEQ_DELAY) |-> r.cnt == 8'h00;
	endproperty
	a_restart: assert property (p_restart) else $error("delay count not restarted");
	property p_flag_cause;
		$rose(r.flag) |-> $past(fault_i);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag set without fault");
	property p_rst_needs_power;
		(CARD_RST_N & ~CARD_POWER_EN) == 2'h0;
	endproperty
	a_rst_needs_power: assert property (p_rst_needs_power) else $error("reset released without power");

	c_delayed: cover property (r.seq == crsf_pkg::SEQ_DELAY ##1 r.seq == crsf_pkg::SEQ_RUN);
	c_hold_release: cover property (r.seq == crsf_pkg::SEQ_HOLD ##1 r.seq == crsf_pkg::SEQ_DELAY);
	c_fault: cover property ($rose(r.flag));

endmodule

// file: src/crsf_map.svh
/*
 * Register offsets, field positions, reset values and write masks of the
 * card reset and supply fault block. Assumes an 8-bit SFR space with
 * 16-bit addresses.
 */
`ifndef CRSF_MAP_SVH
`define CRSF_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CRSF_ADDR_SELECT 16'hfe00
`define CRSF_ADDR_POWER 16'hfe03
`define CRSF_ADDR_CONTACT 16'hfe0a
`define CRSF_ADDR_RLEN 16'hfe22
`define CRSF_ADDR_FAULT 16'hffd4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CRSF_POWER_SEL_HI 7
`define CRSF_POWER_SEL_LO 6
`define CRSF_POWER_FLAG_BIT 5
`define CRSF_POWER_GOOD_BIT 3
`define CRSF_CONTACT_HOLD_BIT 7
`define CRSF_SELECT_HI 3
`define CRSF_SELECT_LO 2
`define CRSF_FAULT_OVR_BIT 6
`define CRSF_FAULT_DIS_BIT 5
`define CRSF_FAULT_TH_HI 2
`define CRSF_FAULT_TH_LO 0

// ----------------------------------------
// Reset values and writable bits
// ----------------------------------------
`define CRSF_RLEN_RESET 8'h70
`define CRSF_CONTACT_RESET 8'h00
`define CRSF_FAULT_RESET 8'h00
`define CRSF_FAULT_WMASK 8'h67
`define CRSF_NUM_IF 2'h2

`endif

// file: src/crsf_pkg.sv
/*
 * Types shared by the card reset and supply fault block.
 * Assumes crsf_map.svh supplies all numeric constants.
 */
package crsf_pkg;

	// ----------------------------------------
	// Sequencer and carriers
	// ----------------------------------------
	typedef enum logic [2:0] {SEQ_OFF, SEQ_WAIT_GOOD, SEQ_HOLD, SEQ_DELAY, SEQ_RUN} crsf_seq_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} crsf_sfr_req_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic stable;
	} crsf_sync_s;

	typedef struct packed {
		crsf_sync_s low;
		logic [2:0] fuse;
		logic fuse_taken;
		logic [2:0] thr;
		logic fault;
	} crsf_fdet_s;

	typedef struct packed {
		crsf_seq_e seq;
		logic [7:0] cnt;
		logic [1:0] vcc_sel;
		logic [7:0] contact;
		logic [7:0] rlen;
		logic [7:0] fctl;
		logic [1:0] if_sel;
		logic flag;
		crsf_sync_s good;
		logic [7:0] rdata;
		logic [1:0] rst_n;
		logic [1:0] pwr;
	} crsf_state_s;

	// Three-stage pin synchroniser; a change counts once stages two and three agree
	function automatic crsf_sync_s crsf_sync_step(crsf_sync_s s, logic d);
		crsf_sync_s o;
		o = s;
		o.s1 = d;
		o.s2 = s.s1;
		o.s3 = s.s2;
		if (s.s2 == s.s3)
		begin
			o.stable = s.s3;
		end
		return o;
	endfunction

endpackage

// file: src/crsf_fault_det.sv
/*
 * Supply fault detector: picks the fault threshold for the analog
 * comparator and qualifies its low-supply result.
 * Assumes the comparator output is asynchronous and the fuse code static.
 */
`timescale 1ns/1ns
`include "crsf_map.svh"

module crsf_fault_det (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Analog side
	input wire logic supply_low,
	input wire logic [2:0] fuse_code,
	// Control
	input wire logic [7:0] fctl,
	// Results
	output logic [2:0] thr_code,
	output logic fault
);

	crsf_pkg::crsf_fdet_s r;
	crsf_pkg::crsf_fdet_s n;

	always_comb
	begin
		n = r;
		n.low = crsf_pkg::crsf_sync_step(r.low, supply_low);
		if (!r.fuse_taken)
		begin
			n.fuse = fuse_code;
			n.fuse_taken = 1'b1;
		end
		// threshold code select; code 0 is 2.3 V, 0.1 V per step
		if (fctl[`CRSF_FAULT_OVR_BIT])
		begin
			n.thr = fctl[`CRSF_FAULT_TH_HI:`CRSF_FAULT_TH_LO];
		end
		else
		begin
			n.thr = n.fuse;
		end
		n.fault = !fctl[`CRSF_FAULT_DIS_BIT] && r.low.stable;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r <= '0;
		end
		else
		begin
			r <= n;
		end
	end

	assign thr_code = r.thr;
	assign fault = r.fault;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_thr_select;
		@(posedge clk) disable iff (!rst_n)
		r.fuse_taken |=> thr_code == ($past(fctl[`CRSF_FAULT_OVR_BIT]) ? $past(fctl[2:0]) : r.fuse);
	endproperty
	a_thr_select: assert property (p_thr_select) else $error("threshold code wrong");

	property p_disable;
		@(posedge clk) disable iff (!rst_n)
		fctl[`CRSF_FAULT_DIS_BIT] |=> !fault;
	endproperty
	a_disable: assert property (p_disable) else $error("fault while disabled");

	property p_fuse_kept;
		@(posedge clk) disable iff (!rst_n)
		r.fuse_taken |=> $stable(r.fuse);
	endproperty
	a_fuse_kept: assert property (p_fuse_kept) else $error("fuse default changed");

endmodule

// file: verification/crsf_card_model.sv
/*
 * Behavioural card contact: answers card power with a supply good level.
 * Assumes the bench clock and an active high power enable from the block.
 */
`timescale 1ns/1ns

module crsf_card_model (
	// Clock
	input wire logic clk,
	// Block side
	input wire logic power_en,
	input wire logic slow,
	// Card supply
	output logic supply_good
);
	int ramp;

	initial
	begin
		ramp = 0;
		supply_good = 1'b0;
	end

	// Supply ramps over a few cycles, or many when slow; it drops at once on power loss
	always @(posedge clk)
	begin
		if (!power_en)
		begin
			ramp <= 0;
			supply_good <= 1'b0;
		end
		else if (ramp < (slow ? 40 : 6))
		begin
			ramp <= ramp + 1;
		end
		else
		begin
			supply_good <= 1'b1;
		end
	end
endmodule

// file: verification/card_reset_and_supply_fault_tb_top.sv
/*
 * Self-checking bench: SFR read and write tasks, ETU ticks and a card model.
 * Assumes the register map header and single-cycle SFR strobes.
 */
`timescale 1ns/1ns
`include "crsf_map.svh"

`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end

module card_reset_and_supply_fault_tb_top;
	logic CLK;
	logic RST_N;
	crsf_pkg::crsf_sfr_req_s SFR_REQ;
	logic [7:0] SFR_RDATA;
	logic ETU_TICK;
	logic CARD_SUPPLY_GOOD;
	logic [1:0] CARD_POWER_EN;
	logic [1:0] CARD_RST_N;
	logic SUPPLY_LOW;
	logic [2:0] FUSE_THRESHOLD;
	logic [2:0] SUPPLY_THRESHOLD;
	logic slow;
	logic [7:0] v;
	int bad_count;
	int checks_done;

	crsf_top crsf_top_inst (.CLK(CLK), .RST_N(RST_N), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
		.ETU_TICK(ETU_TICK), .CARD_SUPPLY_GOOD(CARD_SUPPLY_GOOD), .CARD_POWER_EN(CARD_POWER_EN),
		.CARD_RST_N(CARD_RST_N), .SUPPLY_LOW(SUPPLY_LOW), .FUSE_THRESHOLD(FUSE_THRESHOLD),
		.SUPPLY_THRESHOLD(SUPPLY_THRESHOLD));

	crsf_card_model crsf_card_model_inst (.clk(CLK), .power_en(|CARD_POWER_EN), .slow(slow),
		.supply_good(CARD_SUPPLY_GOOD));

	initial
	begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#10;
	endtask

	// Strobe lowered a full cycle before the next request may raise it
	task automatic sfr_wr(input logic [15:0] a, input logic [7:0] d);
		SFR_REQ = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		cyc(1);
		SFR_REQ.wr = 1'b0;
		cyc(1);
	endtask

	task automatic sfr_rd(input logic [15:0] a, output logic [7:0] d);
		SFR_REQ = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		cyc(1);
		SFR_REQ.rd = 1'b0;
		d = SFR_RDATA;
		cyc(1);
	endtask

	task automatic tick(input int n);
		repeat (n)
		begin
			ETU_TICK = 1'b1;
			cyc(1);
			ETU_TICK = 1'b0;
			cyc(2);
		end
	endtask

	task automatic wait_rst(input int idx, input logic exp, input int limit);
		int i;
		i = 0;
		while (CARD_RST_N[idx] !== exp && i < limit)
		begin
			cyc(1);
			i++;
		end
		`CHECK(CARD_RST_N[idx], exp)
	endtask

	task automatic end_test(input string name);
		$display("Test %s done, mismatches so far %0d", name, bad_count);
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Whole run is a few hundred cycles; the margin covers slow supply ramps
	initial
	begin
		repeat (20000) @(posedge CLK);
		bad_count++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish;
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		bad_count = 0;
		checks_done = 0;
		RST_N = 1'b0;
		SFR_REQ = '0;
		ETU_TICK = 1'b0;
		SUPPLY_LOW = 1'b0;
		FUSE_THRESHOLD = 3'h6;
		slow = 1'b0;
		repeat (3) @(posedge CLK);
		#10;
		RST_N = 1'b1;
		cyc(4);

		sfr_rd(`CRSF_ADDR_RLEN, v);
		`CHECK(v, `CRSF_RLEN_RESET)
		sfr_rd(`CRSF_ADDR_CONTACT, v);
		`CHECK(v, 8'h00)
		sfr_rd(`CRSF_ADDR_FAULT, v);
		`CHECK(v, 8'h00)
		sfr_rd(16'hfe30, v);
		`CHECK(v, 8'h00)
		sfr_wr(`CRSF_ADDR_FAULT, 8'hff);
		sfr_rd(`CRSF_ADDR_FAULT, v);
		`CHECK(v, 8'h67)
		sfr_wr(`CRSF_ADDR_FAULT, 8'h00);
		sfr_wr(`CRSF_ADDR_RLEN, 8'h5a);
		sfr_rd(`CRSF_ADDR_RLEN, v);
		`CHECK(v, 8'h5a)
		`CHECK(SUPPLY_THRESHOLD, 3'h6)
		end_test("registers");

		sfr_wr(`CRSF_ADDR_RLEN, 8'h00);
		sfr_wr(`CRSF_ADDR_SELECT, 8'h00);
		sfr_wr(`CRSF_ADDR_POWER, 8'h40);
		wait_rst(0, 1'b1, 80);
		`CHECK(CARD_POWER_EN, 2'b01)
		`CHECK(CARD_RST_N[1], 1'b0)
		sfr_rd(`CRSF_ADDR_POWER, v);
		`CHECK(v, 8'h48)
		end_test("zero delay");

		sfr_wr(`CRSF_ADDR_RLEN, 8'h03);
		sfr_wr(`CRSF_ADDR_POWER, 8'h00);
		cyc(4);
		`CHECK(CARD_RST_N, 2'b00)
		sfr_wr(`CRSF_ADDR_POWER, 8'h40);
		cyc(40);
		`CHECK(CARD_RST_N[0], 1'b0)
		tick(2);
		`CHECK(CARD_RST_N[0], 1'b0)
		tick(1);
		`CHECK(CARD_RST_N[0], 1'b1)
		end_test("delay");

		sfr_wr(`CRSF_ADDR_CONTACT, 8'h80);
		`CHECK(CARD_RST_N[0], 1'b0)
		tick(5);
		`CHECK(CARD_RST_N[0], 1'b0)
		sfr_wr(`CRSF_ADDR_CONTACT, 8'h00);
		tick(2);
		`CHECK(CARD_RST_N[0], 1'b0)
		tick(1);
		`CHECK(CARD_RST_N[0], 1'b1)
		end_test("hold");

		slow = 1'b1;
		sfr_wr(`CRSF_ADDR_POWER, 8'h00);
		sfr_wr(`CRSF_ADDR_CONTACT, 8'h80);
		sfr_wr(`CRSF_ADDR_POWER, 8'h40);
		cyc(60);
		tick(4);
		`CHECK(CARD_RST_N[0], 1'b0)
		sfr_wr(`CRSF_ADDR_CONTACT, 8'h00);
		tick(2);
		`CHECK(CARD_RST_N[0], 1'b0)
		tick(1);
		`CHECK(CARD_RST_N[0], 1'b1)
		slow = 1'b0;
		end_test("hold at power up");

		for (int i = 0; i < 8; i++)
		begin
			sfr_wr(`CRSF_ADDR_FAULT, 8'h40 | 8'(i));
			cyc(2);
			`CHECK(SUPPLY_THRESHOLD, 3'(i))
		end
		sfr_wr(`CRSF_ADDR_FAULT, 8'h00);
		cyc(2);
		`CHECK(SUPPLY_THRESHOLD, 3'h6)
		end_test("thresholds");

		// Override loaded only once the card is powered and released
		sfr_wr(`CRSF_ADDR_FAULT, 8'h45);
		SUPPLY_LOW = 1'b1;
		cyc(8);
		`CHECK(CARD_POWER_EN, 2'b00)
		`CHECK(CARD_RST_N, 2'b00)
		sfr_rd(`CRSF_ADDR_POWER, v);
		`CHECK(v[5], 1'b1)
		sfr_wr(`CRSF_ADDR_POWER, 8'h20);
		sfr_rd(`CRSF_ADDR_POWER, v);
		`CHECK(v[5], 1'b1)
		SUPPLY_LOW = 1'b0;
		cyc(8);
		sfr_wr(`CRSF_ADDR_POWER, 8'h20);
		sfr_rd(`CRSF_ADDR_POWER, v);
		`CHECK(v[5], 1'b0)
		sfr_wr(`CRSF_ADDR_FAULT, 8'h20);
		sfr_wr(`CRSF_ADDR_RLEN, 8'h00);
		sfr_wr(`CRSF_ADDR_POWER, 8'h40);
		wait_rst(0, 1'b1, 80);
		SUPPLY_LOW = 1'b1;
		cyc(10);
		`CHECK(CARD_POWER_EN, 2'b01)
		`CHECK(CARD_RST_N[0], 1'b1)
		sfr_rd(`CRSF_ADDR_POWER, v);
		`CHECK(v[5], 1'b0)
		SUPPLY_LOW = 1'b0;
		end_test("supply fault");

		sfr_wr(`CRSF_ADDR_POWER, 8'h00);
		sfr_wr(`CRSF_ADDR_SELECT, 8'h04);
		sfr_wr(`CRSF_ADDR_POWER, 8'h40);
		wait_rst(1, 1'b1, 80);
		`CHECK(CARD_POWER_EN, 2'b10)
		`CHECK(CARD_RST_N[0], 1'b0)
		sfr_wr(`CRSF_ADDR_CONTACT, 8'h80);
		`CHECK(CARD_RST_N, 2'b00)
		`CHECK(CARD_POWER_EN, 2'b10)
		sfr_wr(`CRSF_ADDR_SELECT, 8'h08);
		`CHECK(CARD_POWER_EN, 2'b00)
		`CHECK(CARD_RST_N, 2'b00)
		sfr_rd(`CRSF_ADDR_SELECT, v);
		`CHECK(v, 8'h08)
		end_test("external interface");
		tally_and_finish;
	end
endmodule
